/* File: rtcal_pkg.sv */
package rtcal_pkg;

    // ****************************************************************
    // Timing.
    // ****************************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int OSC_HZ = 32_768;
    localparam int TICK_HZ = 256;
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
    localparam int TICK_CNT_W = 24;
    localparam int BUSY_CYCLES = 4;
    localparam logic [2:0] BUSY_LOAD = 3'h4;

    // ****************************************************************
    // Register map (indices; byte address is four times the index).
    // ****************************************************************
    localparam logic [7:0] IDX_CONTROL = 8'h18;
    localparam logic [7:0] IDX_SUBSEC = 8'h1a;
    localparam logic [7:0] IDX_SEC_HIGH = 8'h1b;
    localparam logic [7:0] IDX_SEC_LOW = 8'h1c;
    localparam logic [7:0] IDX_ALARM_HIGH = 8'h1e;
    localparam logic [7:0] IDX_ALARM_LOW = 8'h1f;

    // ****************************************************************
    // Fields.
    // ****************************************************************
    localparam int CTL_ALARM_EN = 0;
    localparam int CTL_RUN_EN = 1;
    localparam int CTL_FLAG = 2;
    localparam int CTL_BUSY = 3;
    localparam int ALARM_BITS = 20;
    localparam int ALARM_HIGH_W = 4;
    localparam logic [7:0] SUBSEC_LAST = 8'hff;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] index;
        logic mapped;
    } rtcal_phase_t;

    typedef struct packed {
        logic alarm_en;
        logic run_en;
    } rtcal_ctl_t;

    function automatic logic [31:0] rtcal_byte_addr(input logic [7:0] idx);
        rtcal_byte_addr = {22'h0, idx, 2'h0};
    endfunction

endpackage : rtcal_pkg

/* File: rtcal_top.sv */
// Local design decision: the AHB-Lite interface to the registers.
module rtcal_top import rtcal_pkg::*; #(
    parameter int TICK_PERIOD = TICK_CYCLES // Clock cycles per 256 Hz tick.
) (
    input wire logic ref_clk, // System clock, 100 MHz.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic hsel, // Slave select.
    input wire logic [31:0] haddr, // Byte address.
    input wire logic [1:0] htrans, // Transfer type.
    input wire logic hwrite, // Write when high.
    input wire logic [2:0] hsize, // Transfer size, word only.
    input wire logic [31:0] hwdata, // Write data.
    input wire logic hready, // Bus ready.
    output logic hreadyout, // Slave ready.
    output logic hresp, // Response, always OKAY.
    output logic [31:0] hrdata, // Read data.
    output logic alarm_flag // Sticky time-of-day alarm flag.
);

    // ****************************************************************
    // State.
    // ****************************************************************
    logic [3:0] alarm_time_high_reg;
    logic [15:0] alarm_time_low_reg;
    logic [7:0] subsecond_count_reg;
    logic [15:0] seconds_count_high_reg;
    logic [15:0] seconds_count_low_reg;
    rtcal_ctl_t ctl_reg;
    logic flag_reg;
    logic [2:0] busy_reg;
    logic [TICK_CNT_W-1:0] tick_cnt_reg;
    logic tick_reg;
    rtcal_phase_t dphase_reg;
    logic [31:0] rdata_next;
    logic [7:0] a_index;
    logic a_mapped;
    logic a_take;
    logic wr_ctl;
    logic wr_sub;
    logic wr_sech;
    logic wr_secl;
    logic wr_ah;
    logic wr_al;
    logic busy;
    logic alarm_open;
    logic count_open;
    logic rollover;
    logic [31:0] sec_next;
    logic [19:0] alarm_value;
    logic alarm_hit;

    assign busy = (busy_reg != 3'h0);
    assign alarm_open = !ctl_reg.alarm_en || !ctl_reg.run_en;
    assign count_open = !ctl_reg.run_en && !busy;

    // ****************************************************************
    // Bus address phase.
    // ****************************************************************
    // The slave never stalls, so hready equals hreadyout here.
    assign a_take = hsel && hready && (htrans == HTRANS_NONSEQ);

    always_comb begin
        a_mapped = 1'b1;
        a_index = 8'h0;
        if (haddr == rtcal_byte_addr(IDX_CONTROL)) begin
            a_index = IDX_CONTROL;
        end else if (haddr == rtcal_byte_addr(IDX_SUBSEC)) begin
            a_index = IDX_SUBSEC;
        end else if (haddr == rtcal_byte_addr(IDX_SEC_HIGH)) begin
            a_index = IDX_SEC_HIGH;
        end else if (haddr == rtcal_byte_addr(IDX_SEC_LOW)) begin
            a_index = IDX_SEC_LOW;
        end else if (haddr == rtcal_byte_addr(IDX_ALARM_HIGH)) begin
            a_index = IDX_ALARM_HIGH;
        end else if (haddr == rtcal_byte_addr(IDX_ALARM_LOW)) begin
            a_index = IDX_ALARM_LOW;
        end else begin
            a_mapped = 1'b0;
        end
    end

    always_comb begin
        rdata_next = 32'h0;
        if (a_index == IDX_CONTROL) begin
            rdata_next[CTL_ALARM_EN] = ctl_reg.alarm_en;
            rdata_next[CTL_RUN_EN] = ctl_reg.run_en;
            rdata_next[CTL_FLAG] = flag_reg;
            rdata_next[CTL_BUSY] = busy;
        end else if (a_index == IDX_SUBSEC) begin
            rdata_next[7:0] = subsecond_count_reg;
        end else if (a_index == IDX_SEC_HIGH) begin
            rdata_next[15:0] = seconds_count_high_reg;
        end else if (a_index == IDX_SEC_LOW) begin
            rdata_next[15:0] = seconds_count_low_reg;
        end else if (a_index == IDX_ALARM_HIGH) begin
            rdata_next[ALARM_HIGH_W-1:0] = alarm_time_high_reg;
        end else if (a_index == IDX_ALARM_LOW) begin
            rdata_next[15:0] = alarm_time_low_reg;
        end
        if (!a_mapped) begin
            rdata_next = 32'h0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dphase_reg <= '0;
        end else if (hready) begin
            dphase_reg.valid <= a_take;
            dphase_reg.write <= hwrite;
            dphase_reg.index <= a_index;
            dphase_reg.mapped <= a_mapped;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hrdata <= 32'h0;
        end else if (a_take && !hwrite) begin
            hrdata <= rdata_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ****************************************************************
    // Write strobes, taken in the data phase.
    // ****************************************************************
    function automatic logic wr_hit(input rtcal_phase_t ph, input logic [7:0] idx);
        wr_hit = ph.valid && ph.write && ph.mapped && (ph.index == idx);
    endfunction

    assign wr_ctl = wr_hit(dphase_reg, IDX_CONTROL);
    assign wr_sub = wr_hit(dphase_reg, IDX_SUBSEC) && count_open;
    assign wr_sech = wr_hit(dphase_reg, IDX_SEC_HIGH) && count_open;
    assign wr_secl = wr_hit(dphase_reg, IDX_SEC_LOW) && count_open;
    assign wr_ah = wr_hit(dphase_reg, IDX_ALARM_HIGH) && alarm_open;
    assign wr_al = wr_hit(dphase_reg, IDX_ALARM_LOW) && alarm_open && !busy;

    // ****************************************************************
    // Control and busy.
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctl_reg <= '0;
        end else if (wr_ctl) begin
            ctl_reg.alarm_en <= hwdata[CTL_ALARM_EN];
            ctl_reg.run_en <= hwdata[CTL_RUN_EN];
        end
    end

    // Busy models the settling of a value moved into the battery-backed
    // counter cells or the alarm low register, so a second update cannot overtake the first.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busy_reg <= 3'h0;
        end else if (wr_sub || wr_sech || wr_secl || wr_al) begin
            busy_reg <= BUSY_LOAD;
        end else if (busy) begin
            busy_reg <= busy_reg - 3'h1;
        end
    end

    // ****************************************************************
    // 256 Hz tick.
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst || !ctl_reg.run_en) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == TICK_CNT_W'(TICK_PERIOD - 1)) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
            tick_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Counter cascade, battery backed, untouched by srst.
    // ****************************************************************
    assign rollover = tick_reg && (subsecond_count_reg == SUBSEC_LAST);
    assign sec_next = {seconds_count_high_reg, seconds_count_low_reg} + 32'h1;

    always_ff @(posedge ref_clk) begin
        if (wr_sub) begin
            subsecond_count_reg <= hwdata[7:0];
        end else if (tick_reg) begin
            subsecond_count_reg <= subsecond_count_reg + 8'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (wr_sech) begin
            seconds_count_high_reg <= hwdata[15:0];
        end else if (rollover) begin
            seconds_count_high_reg <= sec_next[31:16];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (wr_secl) begin
            seconds_count_low_reg <= hwdata[15:0];
        end else if (rollover) begin
            seconds_count_low_reg <= sec_next[15:0];
        end
    end

    // ****************************************************************
    // Alarm registers: no reset and no initial value on purpose.
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (wr_ah) begin
            alarm_time_high_reg <= hwdata[ALARM_HIGH_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (wr_al) begin
            alarm_time_low_reg <= hwdata[15:0];
        end
    end

    // ****************************************************************
    // Alarm compare and flag.
    // ****************************************************************
    assign alarm_value = {alarm_time_high_reg, alarm_time_low_reg};
    // Compared against the seconds value the rollover produces.
    assign alarm_hit = rollover && (alarm_value == sec_next[ALARM_BITS-1:0]);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flag_reg <= 1'b0;
        end else if (alarm_hit && ctl_reg.alarm_en) begin
            flag_reg <= 1'b1;
        end else if (wr_ctl && hwdata[CTL_FLAG]) begin
            flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            alarm_flag <= 1'b0;
        end else begin
            alarm_flag <= flag_reg || (alarm_hit && ctl_reg.alarm_en);
        end
    end

    logic unused_ok;
    assign unused_ok = ^{hsize, hwdata[31:16]};

endmodule // rtcal_top

/* File: rtcal_top_sva.sv */
module rtcal_top_sva import rtcal_pkg::*; (
    input wire logic ref_clk, // Clock.
    input wire logic srst, // Reset.
    input wire logic hsel, // Select.
    input wire logic [31:0] haddr, // Address.
    input wire logic [1:0] htrans, // Transfer type.
    input wire logic hwrite, // Write.
    input wire logic [31:0] hwdata, // Write data.
    input wire logic hready, // Ready in.
    input wire logic hreadyout, // Ready out.
    input wire logic hresp, // Response.
    input wire logic [31:0] hrdata, // Read data.
    input wire logic alarm_flag // Alarm flag.
);
    timeunit 1ns;
    timeprecision 1ps;
    rtcal_phase_t ph_reg;
    logic en_reg;
    logic rd;
    logic clr;
    assign rd = ph_reg.valid && !ph_reg.write;
    assign clr = ph_reg.valid && ph_reg.write && ph_reg.mapped && ph_reg.index == IDX_CONTROL
        && hwdata[CTL_FLAG];
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ph_reg <= '0;
        end else begin
            ph_reg.valid <= hsel && hready && htrans == HTRANS_NONSEQ;
            ph_reg.write <= hwrite;
            ph_reg.index <= haddr[9:2];
            ph_reg.mapped <= haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0 && haddr[9:2] inside
                {IDX_CONTROL, IDX_SUBSEC, IDX_SEC_HIGH, IDX_SEC_LOW, IDX_ALARM_HIGH, IDX_ALARM_LOW};
        end
    end
    // Shadow of the alarm enable, so a flag rise can be tied to its cause.
    always_ff @(posedge ref_clk) begin
        if (srst)
            en_reg <= 1'b0;
        else if (ph_reg.valid && ph_reg.write && ph_reg.mapped && ph_reg.index == IDX_CONTROL)
            en_reg <= hwdata[CTL_ALARM_EN];
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    ready_high_a: assert property (hreadyout) else $error("slave ready dropped");
    okay_resp_a: assert property (!hresp) else $error("response not okay");
    rst_clear_a: assert property ($fell(srst) |-> hrdata == 32'h0 && !alarm_flag)
        else $error("outputs not cleared by reset");
    high_zero_a: assert property (rd && ph_reg.index == IDX_ALARM_HIGH |-> hrdata[31:4] == 28'h0)
        else $error("alarm high upper bits not zero");
    low_width_a: assert property (rd && ph_reg.index == IDX_ALARM_LOW |-> hrdata[31:16] == 16'h0)
        else $error("alarm low wider than 16 bits");
    unmap_zero_a: assert property (rd && !ph_reg.mapped |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property ($changed(hrdata) |-> rd) else $error("read data moved");
    // The clear lands at the end of the data phase and the output flop follows one edge later.
    flag_sticky_a: assert property ($fell(alarm_flag) |-> $past(clr, 2))
        else $error("flag cleared without write");
    // The enable that counts is the one in force at the edge where the flag rose.
    flag_en_a: assert property ($rose(alarm_flag) |-> $past(en_reg))
        else $error("flag set while alarm disabled");
endmodule // rtcal_top_sva

bind rtcal_top rtcal_top_sva i_rtcal_top_sva (.ref_clk, .srst, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .alarm_flag);

/* File: test_rtcal_top.sv */
module test_rtcal_top import rtcal_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp, alarm_flag;
    logic [31:0] hrdata, r;
    logic [7:0] idx_tab [5] = '{IDX_SEC_HIGH, IDX_SEC_LOW, IDX_SUBSEC, IDX_ALARM_HIGH, IDX_ALARM_LOW};
    logic [31:0] val_tab [5] = '{32'h1234, 32'h5, 32'hf0, 32'h4, 32'h6};
    int error_cnt = 0;
    int num_checks = 0;
    assign hready = hreadyout;
    always #5 ref_clk = ~ref_clk;
    rtcal_top #(.TICK_PERIOD(4)) i_rtcal_top (.ref_clk, .srst, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .alarm_flag);
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic chk(input logic [31:0] e);
        num_checks++;
        if (r !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, r, e);
        end
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
        xfer(1'b0, idx, 32'h0);
        chk(e);
    endtask
    task automatic conclude;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        rdc(IDX_CONTROL, 32'h0);
        xfer(1'b1, IDX_ALARM_LOW, 32'hffffabcd);
        // The second write lands while the first still holds the block busy.
        xfer(1'b1, IDX_ALARM_LOW, 32'h1111);
        rdc(IDX_ALARM_LOW, 32'habcd);
        xfer(1'b1, IDX_ALARM_HIGH, 32'hff);
        rdc(IDX_ALARM_HIGH, 32'hf);
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, idx_tab[i], val_tab[i]);
            repeat (4) @(posedge ref_clk);
        end
        for (int i = 0; i < 5; i++) rdc(idx_tab[i], val_tab[i]);
        xfer(1'b1, IDX_CONTROL, 32'h3);
        xfer(1'b1, IDX_ALARM_LOW, 32'h9999);
        xfer(1'b1, IDX_ALARM_HIGH, 32'h1);
        rdc(IDX_ALARM_LOW, 32'h6);
        rdc(IDX_ALARM_HIGH, 32'h4);
        for (int i = 0; i < 200 && alarm_flag !== 1'b1; i++) @(posedge ref_clk);
        r = {31'h0, alarm_flag};
        chk(32'h1);
        rdc(IDX_SEC_LOW, 32'h6);
        rdc(IDX_CONTROL, 32'h7);
        xfer(1'b1, IDX_CONTROL, 32'h7);
        // One more full second passes; seconds no longer match the alarm.
        repeat (1100) @(posedge ref_clk);
        r = {31'h0, alarm_flag};
        chk(32'h0);
        srst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        rdc(IDX_ALARM_LOW, 32'h6);
        rdc(IDX_ALARM_HIGH, 32'h4);
        xfer(1'b1, IDX_CONTROL, 32'h1);
        xfer(1'b1, IDX_ALARM_HIGH, 32'h3);
        rdc(IDX_ALARM_HIGH, 32'h3);
        xfer(1'b1, IDX_SEC_LOW, 32'h2);
        rdc(IDX_CONTROL, 32'h9);
        xfer(1'b1, 8'h10, 32'h5a);
        rdc(8'h10, 32'h0);
        conclude();
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        error_cnt++;
        conclude();
    end
endmodule // test_rtcal_top
